// ### usbcrd_pkg.sv
package usbcrd_pkg;

    // Request type byte values used by the supported requests.
    localparam logic [7:0] RT_DEV_OUT  = 8'h00;
    localparam logic [7:0] RT_IF_OUT   = 8'h01;
    localparam logic [7:0] RT_EP_OUT   = 8'h02;
    localparam logic [7:0] RT_DEV_IN   = 8'h80;
    localparam logic [7:0] RT_EP_IN    = 8'h82;
    localparam logic [7:0] RT_VEND_OUT = 8'h40;
    localparam logic [7:0] RT_VEND_IN  = 8'hC0;

    // Request codes.
    localparam logic [7:0] RQ_GET_STATUS = 8'h00;
    localparam logic [7:0] RQ_CLR_FEAT   = 8'h01;
    localparam logic [7:0] RQ_SET_FEAT   = 8'h03;
    localparam logic [7:0] RQ_SET_ADDR   = 8'h05;
    localparam logic [7:0] RQ_SET_CFG    = 8'h09;
    localparam logic [7:0] RQ_SET_IF     = 8'h0B;
    localparam logic [7:0] RQ_REG_WR     = 8'hA0;
    localparam logic [7:0] RQ_REG_RD     = 8'hA1;

    // Feature selectors, endpoint indices, lengths and values.
    localparam logic [15:0] FEAT_EP_HALT = 16'h0000;
    localparam logic [15:0] FEAT_RWU     = 16'h0001;
    localparam logic [15:0] FEAT_TEST    = 16'h0002;
    localparam logic [15:0] IDX_EP1      = 16'h0081;
    localparam logic [15:0] IDX_EP2      = 16'h0002;
    localparam logic [15:0] IDX_EP3      = 16'h0083;
    localparam logic [15:0] LEN_STATUS   = 16'h0002;
    localparam logic [15:0] LEN_REG      = 16'h0004;
    localparam logic [15:0] CFG_VALUE    = 16'h0001;
    localparam logic [15:0] ZERO16       = 16'h0000;

    // Register addresses at or above this belong to the MAC block.
    localparam logic [11:0] MAC_ADDR_MIN = 12'h100;

    // Setup packet field positions (byte 0 in the low bits).
    localparam int PKT_RT_LSB  = 0;
    localparam int PKT_RQ_LSB  = 8;
    localparam int PKT_VAL_LSB = 16;
    localparam int PKT_IDX_LSB = 32;
    localparam int PKT_LEN_LSB = 48;

    // Host controller APB register offsets.
    localparam logic [7:0] HOFF_REQ0   = 8'h00;
    localparam logic [7:0] HOFF_REQ1   = 8'h04;
    localparam logic [7:0] HOFF_WDATA  = 8'h08;
    localparam logic [7:0] HOFF_CTRL   = 8'h0C;
    localparam logic [7:0] HOFF_STATUS = 8'h10;
    localparam logic [7:0] HOFF_RDATA  = 8'h14;

    // Host status and control bit positions.
    localparam int HST_BUSY  = 0;
    localparam int HST_DONE  = 1;
    localparam int HST_STALL = 2;
    localparam int HCTL_GO   = 0;

    // Maps an endpoint index to a one-hot select of endpoints 3..1.
    function automatic logic [2:0] ep_onehot(input logic [15:0] idx);
        logic [2:0] sel;
        sel = 3'b000;
        if (idx == IDX_EP1) begin
            sel = 3'b001;
        end
        if (idx == IDX_EP2) begin
            sel = 3'b010;
        end
        if (idx == IDX_EP3) begin
            sel = 3'b100;
        end
        return sel;
    endfunction : ep_onehot

endpackage : usbcrd_pkg

// ### usbcrd_link_if.sv
`timescale 1ns/1ps
interface usbcrd_link_if;
    logic        setup_vld;
    logic [63:0] setup_pkt;
    logic        out_vld;
    logic [7:0]  out_byte;
    logic        out_rdy;
    logic        in_vld;
    logic [7:0]  in_byte;
    logic        in_rdy;
    logic        hs_vld;
    logic        hs_stall;
    logic        status_done;

    modport dev (
        input  setup_vld, setup_pkt, out_vld, out_byte, in_rdy, status_done,
        output out_rdy, in_vld, in_byte, hs_vld, hs_stall
    );

    modport host (
        output setup_vld, setup_pkt, out_vld, out_byte, in_rdy, status_done,
        input  out_rdy, in_vld, in_byte, hs_vld, hs_stall
    );
endinterface : usbcrd_link_if

// ### usbcrd_dev.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Device status query: 80h, 00h, length two.
// - Device status: bit0 self powered, bit1 wakeup.
// - Endpoint status query: 82h, index selects endpoint.
// - Endpoint status: stall in bit0, rest zero.
// - Set address 00h/05h adopts value field.
// - Set feature on endpoint sets its halt.
// - Device set feature: wakeup or test mode.
// - Set configuration enters configured state.
// - Only configuration value 01h accepted.
// - Set interface acked only for zeros.
// - Vendor requests reach system and MAC registers.
// - MAC access stalled while not configured.
// - Register write: 40h, A0h, 12-bit address.
// - Write updates one register, one word.
// - Register read: C0h, A1h, 12-bit address.
// - Read returns one full register word.
// - Clear feature clears halt or wakeup.
module usbcrd_dev (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Link toward the host.
    usbcrd_link_if.dev       lnk,
    // Device strap and state.
    input  wire logic        self_powered,
    output logic [6:0]       dev_addr,
    output logic             configured,
    output logic             remote_wakeup,
    output logic             test_mode,
    output logic [2:0]       ep_stall,
    // Register access toward system and MAC blocks.
    output logic             reg_req,
    output logic             reg_we,
    output logic [11:0]      reg_addr,
    output logic [31:0]      reg_wdata,
    output logic             reg_mac,
    input  wire logic        reg_ack,
    input  wire logic [31:0] reg_rdata
);

    ////////////////////////////////////////////////////////////////////////
    // Control state machine.
    typedef enum logic [6:0] {
        ST_IDLE  = 7'b000_0001,
        ST_REGRD = 7'b000_0010,
        ST_SEND  = 7'b000_0100,
        ST_RECV  = 7'b000_1000,
        ST_REGWR = 7'b001_0000,
        ST_HAND  = 7'b010_0000,
        ST_STAT  = 7'b100_0000
    } usbcrd_dst_t;

    usbcrd_dst_t st_r, st_nxt;
    logic [31:0] word_r, word_nxt;
    logic [1:0]  cnt_r, cnt_nxt;
    logic [1:0]  last_r, last_nxt;
    logic [11:0] addr_r, addr_nxt;
    logic        stall_r, stall_nxt;
    logic        apend_r, apend_nxt;
    logic [6:0]  pend_r, pend_nxt;
    logic [6:0]  daddr_r, daddr_nxt;
    logic        cfg_r, cfg_nxt;
    logic        rwu_r, rwu_nxt;
    logic        tst_r, tst_nxt;
    logic [2:0]  eps_r, eps_nxt;

    // Setup packet fields.
    logic [7:0]  rt;
    logic [7:0]  rq;
    logic [15:0] val;
    logic [15:0] idx;
    logic [15:0] len;
    logic [2:0]  ep;
    logic        idx_mac;

    assign rt  = lnk.setup_pkt[usbcrd_pkg::PKT_RT_LSB  +: 8];
    assign rq  = lnk.setup_pkt[usbcrd_pkg::PKT_RQ_LSB  +: 8];
    assign val = lnk.setup_pkt[usbcrd_pkg::PKT_VAL_LSB +: 16];
    assign idx = lnk.setup_pkt[usbcrd_pkg::PKT_IDX_LSB +: 16];
    assign len = lnk.setup_pkt[usbcrd_pkg::PKT_LEN_LSB +: 16];
    assign ep  = usbcrd_pkg::ep_onehot(idx);
    assign idx_mac = (idx[11:0] >= usbcrd_pkg::MAC_ADDR_MIN);

    // Decode, data stage and status stage sequencing. Feature and
    // configuration effects apply at decode; the address waits for the
    // status stage since the host still talks to the old address there.
    always_comb begin
        st_nxt    = st_r;
        word_nxt  = word_r;
        cnt_nxt   = cnt_r;
        last_nxt  = last_r;
        addr_nxt  = addr_r;
        stall_nxt = stall_r;
        apend_nxt = apend_r;
        pend_nxt  = pend_r;
        daddr_nxt = daddr_r;
        cfg_nxt   = cfg_r;
        rwu_nxt   = rwu_r;
        tst_nxt   = tst_r;
        eps_nxt   = eps_r;
        unique case (st_r)
            ST_IDLE: begin
                if (lnk.setup_vld) begin
                    st_nxt    = ST_HAND;
                    stall_nxt = 1'b1;
                    apend_nxt = 1'b0;
                    cnt_nxt   = 2'd0;
                    last_nxt  = 2'd1;
                    addr_nxt  = idx[11:0];
                    if (rt == usbcrd_pkg::RT_DEV_IN
                        && rq == usbcrd_pkg::RQ_GET_STATUS
                        && val == usbcrd_pkg::ZERO16
                        && idx == usbcrd_pkg::ZERO16
                        && len == usbcrd_pkg::LEN_STATUS) begin
                        word_nxt = {30'd0, rwu_r, self_powered};
                        st_nxt   = ST_SEND;
                    end
                    if (rt == usbcrd_pkg::RT_EP_IN
                        && rq == usbcrd_pkg::RQ_GET_STATUS
                        && val == usbcrd_pkg::ZERO16 && ep != 3'b000
                        && len == usbcrd_pkg::LEN_STATUS) begin
                        word_nxt = {31'd0, |(eps_r & ep)};
                        st_nxt   = ST_SEND;
                    end
                    if (rt == usbcrd_pkg::RT_DEV_OUT
                        && rq == usbcrd_pkg::RQ_SET_ADDR
                        && idx == usbcrd_pkg::ZERO16
                        && len == usbcrd_pkg::ZERO16
                        && val[15:7] == 9'd0) begin
                        apend_nxt = 1'b1;
                        pend_nxt  = val[6:0];
                        stall_nxt = 1'b0;
                    end
                    if ((rq == usbcrd_pkg::RQ_SET_FEAT
                         || rq == usbcrd_pkg::RQ_CLR_FEAT)
                        && len == usbcrd_pkg::ZERO16) begin
                        if (rt == usbcrd_pkg::RT_EP_OUT && ep != 3'b000
                            && val == usbcrd_pkg::FEAT_EP_HALT) begin
                            stall_nxt = 1'b0;
                            if (rq == usbcrd_pkg::RQ_SET_FEAT) begin
                                eps_nxt = eps_r | ep;
                            end else begin
                                eps_nxt = eps_r & ~ep;
                            end
                        end
                        if (rt == usbcrd_pkg::RT_DEV_OUT
                            && idx == usbcrd_pkg::ZERO16
                            && val == usbcrd_pkg::FEAT_RWU) begin
                            stall_nxt = 1'b0;
                            // Set turns wakeup on, clear off.
                            rwu_nxt = (rq == usbcrd_pkg::RQ_SET_FEAT);
                        end
                        if (rt == usbcrd_pkg::RT_DEV_OUT
                            && rq == usbcrd_pkg::RQ_SET_FEAT
                            && idx == usbcrd_pkg::ZERO16
                            && val == usbcrd_pkg::FEAT_TEST) begin
                            stall_nxt = 1'b0;
                            tst_nxt   = 1'b1;
                        end
                    end
                    if (rt == usbcrd_pkg::RT_DEV_OUT
                        && rq == usbcrd_pkg::RQ_SET_CFG
                        && idx == usbcrd_pkg::ZERO16
                        && len == usbcrd_pkg::ZERO16
                        && val == usbcrd_pkg::CFG_VALUE) begin
                        cfg_nxt   = 1'b1;
                        stall_nxt = 1'b0;
                    end
                    if (rt == usbcrd_pkg::RT_IF_OUT
                        && rq == usbcrd_pkg::RQ_SET_IF
                        && val == usbcrd_pkg::ZERO16
                        && idx == usbcrd_pkg::ZERO16
                        && len == usbcrd_pkg::ZERO16) begin
                        stall_nxt = 1'b0;
                    end
                    if (val == usbcrd_pkg::ZERO16 && idx[15:12] == 4'h0
                        && len == usbcrd_pkg::LEN_REG
                        && (cfg_r || !idx_mac)) begin
                        if (rt == usbcrd_pkg::RT_VEND_OUT
                            && rq == usbcrd_pkg::RQ_REG_WR) begin
                            st_nxt    = ST_RECV;
                            stall_nxt = 1'b0;
                        end
                        if (rt == usbcrd_pkg::RT_VEND_IN
                            && rq == usbcrd_pkg::RQ_REG_RD) begin
                            st_nxt   = ST_REGRD;
                            last_nxt = 2'd3;
                        end
                    end
                    if (st_nxt == ST_SEND || st_nxt == ST_REGRD) begin
                        stall_nxt = 1'b0;
                    end
                end
            end
            ST_REGRD: begin
                if (reg_ack) begin
                    word_nxt = reg_rdata;
                    st_nxt   = ST_SEND;
                end
            end
            ST_SEND: begin
                if (lnk.in_rdy) begin
                    word_nxt = {8'h00, word_r[31:8]};
                    cnt_nxt  = cnt_r + 2'd1;
                    if (cnt_r == last_r) begin
                        st_nxt = ST_HAND;
                    end
                end
            end
            ST_RECV: begin
                if (lnk.out_vld) begin
                    word_nxt = {lnk.out_byte, word_r[31:8]};
                    cnt_nxt  = cnt_r + 2'd1;
                    if (cnt_r == 2'd3) begin
                        st_nxt = ST_REGWR;
                    end
                end
            end
            ST_REGWR: begin
                if (reg_ack) begin
                    st_nxt = ST_HAND;
                end
            end
            ST_HAND: begin
                st_nxt = stall_r ? ST_IDLE : ST_STAT;
            end
            ST_STAT: begin
                if (lnk.status_done) begin
                    st_nxt = ST_IDLE;
                    if (apend_r) begin
                        daddr_nxt = pend_r;
                        apend_nxt = 1'b0;
                    end
                end
            end
        endcase
    end

    // Registers of the decoder; all reset to an unaddressed, unconfigured
    // device with no halted endpoints.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r    <= ST_IDLE;
            word_r  <= 32'h0000_0000;
            cnt_r   <= 2'd0;
            last_r  <= 2'd0;
            addr_r  <= 12'h000;
            stall_r <= 1'b0;
            apend_r <= 1'b0;
            pend_r  <= 7'd0;
            daddr_r <= 7'd0;
            cfg_r   <= 1'b0;
            rwu_r   <= 1'b0;
            tst_r   <= 1'b0;
            eps_r   <= 3'b000;
        end else begin
            st_r    <= st_nxt;
            word_r  <= word_nxt;
            cnt_r   <= cnt_nxt;
            last_r  <= last_nxt;
            addr_r  <= addr_nxt;
            stall_r <= stall_nxt;
            apend_r <= apend_nxt;
            pend_r  <= pend_nxt;
            daddr_r <= daddr_nxt;
            cfg_r   <= cfg_nxt;
            rwu_r   <= rwu_nxt;
            tst_r   <= tst_nxt;
            eps_r   <= eps_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs. Handshakes decode the state; data come from flip-flops.
    assign lnk.in_vld   = (st_r == ST_SEND);
    assign lnk.in_byte  = word_r[7:0];
    assign lnk.out_rdy  = (st_r == ST_RECV);
    assign lnk.hs_vld   = (st_r == ST_HAND);
    assign lnk.hs_stall = stall_r;
    assign reg_req      = (st_r == ST_REGRD) || (st_r == ST_REGWR);
    assign reg_we       = (st_r == ST_REGWR);
    assign reg_addr     = addr_r;
    assign reg_wdata    = word_r;
    assign reg_mac      = (addr_r >= usbcrd_pkg::MAC_ADDR_MIN);
    assign dev_addr     = daddr_r;
    assign configured   = cfg_r;
    assign remote_wakeup = rwu_r;
    assign test_mode    = tst_r;
    assign ep_stall     = eps_r;

endmodule : usbcrd_dev

// ### usbcrd_host.sv
`timescale 1ns/1ps
module usbcrd_host (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Link toward the device.
    usbcrd_link_if.host      lnk
);

    ////////////////////////////////////////////////////////////////////////
    // Transfer state machine.
    typedef enum logic [3:0] {
        HS_IDLE  = 4'b0001,
        HS_SETUP = 4'b0010,
        HS_XFER  = 4'b0100,
        HS_STAT  = 4'b1000
    } usbcrd_hst_t;

    usbcrd_hst_t st_r, st_nxt;
    logic [31:0] req0_r, req0_nxt;
    logic [31:0] req1_r, req1_nxt;
    logic [31:0] wdat_r, wdat_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    logic [31:0] osh_r, osh_nxt;
    logic [2:0]  ocnt_r, ocnt_nxt;
    logic [1:0]  icnt_r, icnt_nxt;
    logic        done_r, done_nxt;
    logic        stl_r, stl_nxt;
    logic        wr_acc;
    logic        go;
    logic [15:0] wlen;

    assign wr_acc = psel && penable && pwrite;
    assign go     = wr_acc && paddr == usbcrd_pkg::HOFF_CTRL
                    && pwdata[usbcrd_pkg::HCTL_GO] && st_r == HS_IDLE;
    assign wlen   = req1_r[31:16];

    // Register writes, OUT bytes (low byte first) and IN collection. A
    // start while busy is ignored so a running transfer is never torn.
    always_comb begin
        st_nxt   = st_r;
        req0_nxt = req0_r;
        req1_nxt = req1_r;
        wdat_nxt = wdat_r;
        rdat_nxt = rdat_r;
        osh_nxt  = osh_r;
        ocnt_nxt = ocnt_r;
        icnt_nxt = icnt_r;
        done_nxt = done_r;
        stl_nxt  = stl_r;
        if (wr_acc && st_r == HS_IDLE) begin
            if (paddr == usbcrd_pkg::HOFF_REQ0) begin
                req0_nxt = pwdata;
            end
            if (paddr == usbcrd_pkg::HOFF_REQ1) begin
                req1_nxt = pwdata;
            end
            if (paddr == usbcrd_pkg::HOFF_WDATA) begin
                wdat_nxt = pwdata;
            end
        end
        unique case (st_r)
            HS_IDLE: begin
                if (go) begin
                    st_nxt   = HS_SETUP;
                    done_nxt = 1'b0;
                    stl_nxt  = 1'b0;
                    osh_nxt  = wdat_r;
                    icnt_nxt = 2'd0;
                    rdat_nxt = 32'h0000_0000;
                    ocnt_nxt = (req0_r[7] || wlen == 16'h0000) ? 3'd0
                             : (wlen > 16'h0004) ? 3'd4 : wlen[2:0];
                end
            end
            HS_SETUP: begin
                st_nxt = HS_XFER;
            end
            HS_XFER: begin
                if (lnk.out_rdy && ocnt_r != 3'd0) begin
                    osh_nxt  = {8'h00, osh_r[31:8]};
                    ocnt_nxt = ocnt_r - 3'd1;
                end
                if (lnk.in_vld) begin
                    rdat_nxt[{icnt_r, 3'b000} +: 8] = lnk.in_byte;
                    icnt_nxt = icnt_r + 2'd1;
                end
                if (lnk.hs_vld) begin
                    if (lnk.hs_stall) begin
                        st_nxt   = HS_IDLE;
                        stl_nxt  = 1'b1;
                        done_nxt = 1'b1;
                    end else begin
                        st_nxt = HS_STAT;
                    end
                end
            end
            HS_STAT: begin
                st_nxt   = HS_IDLE;
                done_nxt = 1'b1;
            end
        endcase
    end

    // Registers of the host controller.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r   <= HS_IDLE;
            req0_r <= 32'h0000_0000;
            req1_r <= 32'h0000_0000;
            wdat_r <= 32'h0000_0000;
            rdat_r <= 32'h0000_0000;
            osh_r  <= 32'h0000_0000;
            ocnt_r <= 3'd0;
            icnt_r <= 2'd0;
            done_r <= 1'b0;
            stl_r  <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            req0_r <= req0_nxt;
            req1_r <= req1_nxt;
            wdat_r <= wdat_nxt;
            rdat_r <= rdat_nxt;
            osh_r  <= osh_nxt;
            ocnt_r <= ocnt_nxt;
            icnt_r <= icnt_nxt;
            done_r <= done_nxt;
            stl_r  <= stl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB read mux; unmapped offsets read zero and never error.
    always_comb begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            usbcrd_pkg::HOFF_REQ0:   prdata = req0_r;
            usbcrd_pkg::HOFF_REQ1:   prdata = req1_r;
            usbcrd_pkg::HOFF_WDATA:  prdata = wdat_r;
            usbcrd_pkg::HOFF_RDATA:  prdata = rdat_r;
            usbcrd_pkg::HOFF_STATUS: begin
                prdata[usbcrd_pkg::HST_BUSY]  = (st_r != HS_IDLE);
                prdata[usbcrd_pkg::HST_DONE]  = done_r;
                prdata[usbcrd_pkg::HST_STALL] = stl_r;
            end
            default: prdata = 32'h0000_0000;
        endcase
    end

    assign pready          = 1'b1;
    assign pslverr         = 1'b0;
    assign lnk.setup_vld   = (st_r == HS_SETUP);
    assign lnk.setup_pkt   = {req1_r, req0_r};
    assign lnk.out_vld     = (st_r == HS_XFER) && ocnt_r != 3'd0;
    assign lnk.out_byte    = osh_r[7:0];
    assign lnk.in_rdy      = (st_r == HS_XFER);
    assign lnk.status_done = (st_r == HS_STAT);

endmodule : usbcrd_host

// ### usbcrd_link_asserts.sv
`timescale 1ns/1ps
module usbcrd_link_asserts (
    // Clock and reset.
    input wire logic        pclk,
    input wire logic        presetn,
    // Link signals under watch.
    input wire logic        setup_vld,
    input wire logic [63:0] setup_pkt,
    input wire logic        out_rdy,
    input wire logic        in_vld,
    input wire logic        hs_vld,
    input wire logic        hs_stall,
    input wire logic        status_done
);
    // Packet fields, split once so the properties stay short.
    logic [7:0]  rt, rq;
    logic [15:0] val, idx, len;
    assign {len, idx, val, rq, rt} = setup_pkt;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    property p_setif_ack;
        setup_vld && rt == 8'h01 && rq == 8'h0B && {val, idx} == '0
            && len == '0 |-> ##[1:2] hs_vld && !hs_stall;
    endproperty
    a_setif_ack: assert property (p_setif_ack)
        else $error("set interface not acked");
    property p_setif_stall;
        setup_vld && rt == 8'h01 && rq == 8'h0B && val != '0
            |-> ##[1:2] hs_vld && hs_stall;
    endproperty
    a_setif_stall: assert property (p_setif_stall)
        else $error("set interface not stalled");
    property p_cfg_stall;
        setup_vld && rt == 8'h00 && rq == 8'h09 && val != 16'h0001
            |-> ##[1:2] hs_vld && hs_stall;
    endproperty
    a_cfg_stall: assert property (p_cfg_stall)
        else $error("bad configuration not stalled");
    property p_unk_stall;
        setup_vld && rq == 8'h77 |-> ##[1:2] hs_vld && hs_stall;
    endproperty
    a_unk_stall: assert property (p_unk_stall)
        else $error("unknown request not stalled");
    // A stalled request has no status stage to complete.
    property p_quiet;
        hs_vld && hs_stall |=> !status_done [*2];
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("status stage after stall");
    property p_stat_in;
        setup_vld && rt == 8'h80 && rq == 8'h00 && {val, idx} == '0
            && len == 16'h0002 |-> ##[1:3] in_vld;
    endproperty
    a_stat_in: assert property (p_stat_in)
        else $error("status reply missing");
    property p_rd_in;
        setup_vld && rt == 8'hC0 && rq == 8'hA1 && idx < 16'h0100
            && val == '0 && len == 16'h0004 |-> ##[1:20] in_vld;
    endproperty
    a_rd_in: assert property (p_rd_in)
        else $error("register read reply missing");
    property p_wr_out;
        setup_vld && rt == 8'h40 && rq == 8'hA0 && idx < 16'h0100
            && val == '0 && len == 16'h0004 |-> ##[1:2] out_rdy;
    endproperty
    a_wr_out: assert property (p_wr_out)
        else $error("register write data not taken");
endmodule : usbcrd_link_asserts

// ### usb_control_request_decoder_tb.sv
`timescale 1ns/1ps
module usb_control_request_decoder_tb;
    // Bench signals; the register side answers one cycle after a request.
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, self_powered = 1'b1;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, reg_wdata, rd, smp, last_w = '0;
    logic [31:0] reg_rdata = '0;
    logic [6:0] dev_addr, hs_addr = '0;
    logic [2:0] ep_stall;
    logic [11:0] reg_addr;
    logic configured, remote_wakeup, test_mode, reg_req, reg_we, reg_mac;
    logic reg_ack = 1'b0, last_mac = 1'b0;
    int err_count = 0, checked = 0;
    // Rows: stall flag, request words, expected read-back data.
    logic [99:0] rows [19] = '{
        100'h0_0001_0300_0000_0000_0000_0000,
        100'h0_0000_0080_0002_0000_0000_0003,
        100'h0_0001_0100_0000_0000_0000_0000,
        100'h0_0000_0080_0002_0000_0000_0001,
        100'h0_0000_0302_0000_0083_0000_0000,
        100'h0_0000_0082_0002_0083_0000_0001,
        100'h0_0000_0082_0002_0081_0000_0000,
        100'h0_0000_0B01_0000_0000_0000_0000,
        100'h1_0001_0B01_0000_0000_0000_0000,
        100'h1_0002_0900_0000_0000_0000_0000,
        100'h1_0000_A1C0_0004_0100_0000_0000,
        100'h0_0000_A040_0004_0012_0000_0000,
        100'h0_0000_A1C0_0004_0034_A5A5_A034,
        100'h0_0001_0900_0000_0000_0000_0000,
        100'h0_0000_A1C0_0004_0100_A5A5_A100,
        100'h1_0000_7700_0000_0000_0000_0000,
        100'h0_0000_0302_0000_0002_0000_0000,
        100'h0_0000_0102_0000_0083_0000_0000,
        100'h0_0002_0300_0000_0000_0000_0000};
    usbcrd_link_if lnk ();
    usbcrd_host i_usbcrd_host (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .lnk);
    usbcrd_dev i_usbcrd_dev (.pclk, .presetn, .lnk, .self_powered,
        .dev_addr, .configured, .remote_wakeup, .test_mode, .ep_stall,
        .reg_req, .reg_we, .reg_addr, .reg_wdata, .reg_mac, .reg_ack,
        .reg_rdata);
    usbcrd_link_asserts i_usbcrd_link_asserts (.pclk, .presetn,
        .setup_vld(lnk.setup_vld), .setup_pkt(lnk.setup_pkt),
        .out_rdy(lnk.out_rdy), .in_vld(lnk.in_vld), .hs_vld(lnk.hs_vld),
        .hs_stall(lnk.hs_stall), .status_done(lnk.status_done));
    initial forever #25 pclk = ~pclk;
    // Read data is sampled on the edge so no race with the flops.
    always @(posedge pclk) begin
        smp <= prdata;
        reg_ack <= reg_req && !reg_ack;
        reg_rdata <= {20'hA5A5_A, reg_addr};
        if (reg_ack && reg_we) last_w <= reg_wdata;
        if (reg_ack) last_mac <= reg_mac;
        if (lnk.hs_vld) hs_addr <= dev_addr;
    end
    ////////////////////////////////////////////////////////////////////////
    task print_verdict;
        if (err_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 9; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        {psel, penable} <= 2'b00;
        @(negedge pclk);
        rd = smp;
        if (n == 9) begin err_count++; print_verdict(); end
    endtask : apb
    task run(input logic [99:0] r);
        int n;
        apb(1'b1, usbcrd_pkg::HOFF_REQ0, r[95:64]);
        apb(1'b1, usbcrd_pkg::HOFF_REQ1, r[63:32]);
        apb(1'b1, usbcrd_pkg::HOFF_WDATA, 32'h1234_5678);
        apb(1'b1, usbcrd_pkg::HOFF_CTRL, 32'h0000_0001);
        for (n = 0; n < 50 && rd[usbcrd_pkg::HST_DONE] !== 1'b1; n++)
            apb(1'b0, usbcrd_pkg::HOFF_STATUS, '0);
        if (n == 50) begin err_count++; print_verdict(); end
        else begin
            chk("stall", r[99:96], rd[usbcrd_pkg::HST_STALL]);
            apb(1'b0, usbcrd_pkg::HOFF_RDATA, '0);
            chk("rdata", r[31:0], rd);
        end
    endtask : run
    // Main sequence: reset, table of requests, then state and address.
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk("reset addr", '0, dev_addr);
        for (int i = 0; i < 19; i++) run(rows[i]);
        chk("write data", 32'h1234_5678, last_w);
        chk("configured", 32'h1, configured);
        chk("test mode", 32'h1, test_mode);
        chk("ep stall", 32'h2, ep_stall);
        chk("mac flag", 32'h1, last_mac);
        run(100'h0_0005_0500_0000_0000_0000_0000);
        chk("early addr", '0, hs_addr);
        chk("new addr", 32'h5, dev_addr);
        print_verdict();
    end
endmodule : usb_control_request_decoder_tb
